// ===== rtl/test_bus_mapper.sv
/*
  reorders the low 7 bits of the 8-bit test bus into data port pin order and picks the
  single bit for the signal output.
  assumes a purely combinational path; the caller registers results.
*/
`timescale 1ns/1ps
`default_nettype none

module test_bus_mapper (
  input wire logic [7:0] test_bus_i,
  input wire logic [2:0] observe_bit_select_i,
  input wire logic bus_reorder_enable_i,
  output logic [6:0] port_bits_o,
  output logic observe_bit_o
);

  // ---------------------------------------------------------------
  // pin order D4, D3, D2, D6, D5, D0, D1 from bus bit 6 down to 0
  // ---------------------------------------------------------------
  always_comb begin
    if (bus_reorder_enable_i) begin
      port_bits_o[4] = test_bus_i[6];
      port_bits_o[3] = test_bus_i[5];
      port_bits_o[2] = test_bus_i[4];
      port_bits_o[6] = test_bus_i[3];
      port_bits_o[5] = test_bus_i[2];
      port_bits_o[0] = test_bus_i[1];
      port_bits_o[1] = test_bus_i[0];
    end else begin
      port_bits_o = test_bus_i[6:0];
    end
  end

  // single observed bit
  assign observe_bit_o = test_bus_i[observe_bit_select_i];

endmodule // test_bus_mapper

`default_nettype wire

// ===== rtl/test_page_config.sv
/*
  test-page register bank: page override, secure clock routing,
  test bus observation, prbs enables and data-port gpio.
  assumes the host port already decodes protocol framing and gives a
  one-cycle write or read strobe with a latched address; the host
  interface kind and the test bus come from elsewhere in the device.
*/
`timescale 1ns/1ps
`default_nettype none

module test_page_config (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire test_page_pkg::register_access_type access_i,
  input wire logic [5:0] pin_address_i,
  input wire logic pin_address_valid_i,
  input wire test_page_pkg::host_interface_type host_interface_i,
  input wire logic [7:0] test_bus_i,
  input wire logic transmit_command_i,
  input wire logic clock_oscillator_i,
  input wire logic clock_uart_i,
  input wire logic clock_rf_field_i,
  input wire logic [6:0] data_pin_i,
  output logic [6:0] data_pin_o,
  output logic [6:0] data_pin_oe_o,
  output logic [5:0] register_address_o,
  output logic [7:0] read_data_o,
  output logic read_valid_o,
  output logic signal_output_pin_o,
  output logic uart_aux_line_one_oe_o,
  output logic uart_aux_line_two_oe_o,
  output logic prbs9_send_o,
  output logic prbs15_send_o,
  output test_page_pkg::test_control_type test_control_o
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] page_select_reg;
  logic [7:0] signal_select_one_reg;
  logic [7:0] signal_select_two_reg;
  logic [7:0] pin_output_enable_reg;
  logic [7:0] pin_value_reg;
  logic [6:0] mapped_bus;
  logic observe_bit;
  logic serial_host;
  logic secure_clock;
  logic secure_clock_routed;
  logic gpio_active;
  logic [6:0] usable_pins;
  logic [6:0] gpio_enables;
  logic [5:0] address_next;
  logic [7:0] read_next;
  logic aux_lines_on;

  // true for any of the serial host interfaces
  function automatic logic is_serial(
    input test_page_pkg::host_interface_type kind
  );
    is_serial = (kind != test_page_pkg::host_parallel);
  endfunction

  // the clock-source field as its enum; read in two places
  function automatic test_page_pkg::secure_clock_source_type source_of(
    input logic [7:0] select_one
  );
    source_of = test_page_pkg::secure_clock_source_type'(
      select_one[test_page_pkg::secure_clock_lsb +: 2]);
  endfunction

  // send flag: cleared with its enable, set by the command while armed
  function automatic logic send_next(
    input logic enable,
    input logic command,
    input logic current
  );
    send_next = enable && (command || current);
  endfunction

  // write strobe for one offset
  function automatic logic write_hit(
    input test_page_pkg::register_access_type acc,
    input logic [5:0] offset
  );
    write_hit = acc.write && (acc.address == offset);
  endfunction

  assign serial_host = is_serial(host_interface_i);

  // ---------------------------------------------------------------
  // register address formation
  // ---------------------------------------------------------------
  // latch comes from the host port; pins override the low bits, and bits 5 and 4 too while page override is clear
  always_comb begin
    address_next = access_i.address;
    if (pin_address_valid_i) begin
      address_next[3:0] = pin_address_i[3:0];
    end
    if (page_select_reg[test_page_pkg::page_override_bit]) begin
      address_next[5:4] = page_select_reg[1:0];
    end else if (pin_address_valid_i) begin
      address_next[5:4] = pin_address_i[5:4];
    end
  end

  // registered so downstream decode sees one settled address
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      register_address_o <= 6'h00;
    end else begin
      register_address_o <= address_next;
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // reserved page bits 6 to 2 are held at zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      page_select_reg <= test_page_pkg::page_select_reset;
    end else if (write_hit(access_i,
                           test_page_pkg::page_select_offset)) begin
      page_select_reg <= access_i.write_data &
                         test_page_pkg::page_writable_mask;
    end
  end

  // secure clock, D1 routing and observed bit live here
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      signal_select_one_reg <= test_page_pkg::signal_select_one_reset;
    end else if (write_hit(access_i,
                           test_page_pkg::signal_select_one_offset)) begin
      signal_select_one_reg <= access_i.write_data;
    end
  end

  // host must set transmit registers before the prbs bits
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      signal_select_two_reg <= test_page_pkg::signal_select_two_reset;
    end else if (write_hit(access_i,
                           test_page_pkg::signal_select_two_offset)) begin
      signal_select_two_reg <= access_i.write_data;
    end
  end

  // bit 7 resets high so uart aux lines start enabled
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_output_enable_reg <= test_page_pkg::pin_output_enable_reset;
    end else if (write_hit(access_i,
                           test_page_pkg::pin_output_enable_offset)) begin
      pin_output_enable_reg <= access_i.write_data;
    end
  end

  // bit 7 switches the data port over to gpio use
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_value_reg <= test_page_pkg::pin_value_reset;
    end else if (write_hit(access_i,
                           test_page_pkg::pin_value_offset)) begin
      pin_value_reg <= access_i.write_data;
    end
  end

  // ---------------------------------------------------------------
  // test bus observation
  // ---------------------------------------------------------------
  test_bus_mapper mapper (
    .test_bus_i(test_bus_i),
    .observe_bit_select_i(signal_select_one_reg[2:0]),
    .bus_reorder_enable_i(
      signal_select_two_reg[test_page_pkg::reorder_bit]),
    .port_bits_o(mapped_bus),
    .observe_bit_o(observe_bit)
  );

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      signal_output_pin_o <= 1'b0;
    end else begin
      signal_output_pin_o <= observe_bit;
    end
  end

  // ---------------------------------------------------------------
  // secure-module clock selection
  // ---------------------------------------------------------------
  // clocks arrive as sampled levels; a true clock mux sits elsewhere
  always_comb begin
    unique case (source_of(signal_select_one_reg))
      test_page_pkg::clock_off: secure_clock = 1'b0;
      test_page_pkg::clock_oscillator: secure_clock = clock_oscillator_i;
      test_page_pkg::clock_uart: secure_clock = clock_uart_i;
      test_page_pkg::clock_rf_field: secure_clock = clock_rf_field_i;
    endcase
  end

  // parallel host owns the port, so no routing there
  assign secure_clock_routed =
    signal_select_one_reg[test_page_pkg::secure_clock_d1_bit] &&
    serial_host;

  // ---------------------------------------------------------------
  // data port gpio
  // ---------------------------------------------------------------
  // gpio needs a serial host; a parallel host owns the port
  assign gpio_active =
    pin_value_reg[test_page_pkg::gpio_mode_bit] && serial_host;

  // spi, or uart with aux lines, claims D5 and D6
  always_comb begin
    usable_pins = test_page_pkg::pin_mask_reserved;
    if (host_interface_i == test_page_pkg::host_spi || aux_lines_on) begin
      usable_pins = test_page_pkg::narrow_pin_mask;
    end
  end

  always_comb begin
    gpio_enables = 7'h00;
    if (gpio_active) begin
      gpio_enables = pin_output_enable_reg[6:0] & usable_pins;
    end
    if (secure_clock_routed) begin
      gpio_enables[test_page_pkg::secure_clock_pin] = 1'b0;
    end
  end

  // pin drivers registered; undriven pins are left as inputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_pin_o <= 7'h00;
      data_pin_oe_o <= 7'h00;
    end else begin
      data_pin_o <= pin_value_reg[6:0] & gpio_enables;
      data_pin_oe_o <= gpio_enables;
      if (secure_clock_routed) begin
        data_pin_o[test_page_pkg::secure_clock_pin] <= secure_clock;
        data_pin_oe_o[test_page_pkg::secure_clock_pin] <= 1'b1;
      end else if (!gpio_active && !serial_host) begin
        data_pin_oe_o <= 7'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // uart auxiliary lines
  // ---------------------------------------------------------------
  // aux lines live only under a uart host with the enable bit set
  assign aux_lines_on =
    pin_output_enable_reg[test_page_pkg::uart_aux_bit] &&
    host_interface_i == test_page_pkg::host_uart;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      uart_aux_line_one_oe_o <= 1'b0;
      uart_aux_line_two_oe_o <= 1'b0;
    end else begin
      uart_aux_line_one_oe_o <= aux_lines_on;
      uart_aux_line_two_oe_o <= aux_lines_on;
    end
  end

  // ---------------------------------------------------------------
  // prbs control
  // ---------------------------------------------------------------
  // enable alone arms the generator; the send command starts it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prbs9_send_o <= 1'b0;
      prbs15_send_o <= 1'b0;
    end else begin
      prbs9_send_o <= send_next(
        signal_select_two_reg[test_page_pkg::prbs9_bit],
        transmit_command_i, prbs9_send_o);
      prbs15_send_o <= send_next(
        signal_select_two_reg[test_page_pkg::prbs15_bit],
        transmit_command_i, prbs15_send_o);
    end
  end

  // registered copy for the test bus and prbs blocks
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      test_control_o <= '0;
    end else begin
      test_control_o.prbs9_enable <=
        signal_select_two_reg[test_page_pkg::prbs9_bit];
      test_control_o.prbs15_enable <=
        signal_select_two_reg[test_page_pkg::prbs15_bit];
      test_control_o.observe_bus_select <=
        signal_select_two_reg[4:0];
      test_control_o.observe_bit_select <= signal_select_one_reg[2:0];
      test_control_o.secure_clock_source <=
        source_of(signal_select_one_reg);
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  // unmapped offsets show the mapped test bus, reordered only while the reorder bit is set
  always_comb begin
    read_next = 8'h00;
    unique case (access_i.address)
      test_page_pkg::page_select_offset: read_next = page_select_reg;
      test_page_pkg::signal_select_one_offset:
        read_next = signal_select_one_reg;
      test_page_pkg::signal_select_two_offset:
        read_next = signal_select_two_reg;
      test_page_pkg::pin_output_enable_offset:
        read_next = pin_output_enable_reg;
      test_page_pkg::pin_value_offset: begin
        if (pin_value_reg[test_page_pkg::gpio_mode_bit]) begin
          read_next = {1'b1, data_pin_i};
        end else begin
          read_next = pin_value_reg;
        end
      end
      default: read_next = {1'b0, mapped_bus};
    endcase
  end

  // data holds until the next read, so a late fetch still works
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      read_data_o <= 8'h00;
      read_valid_o <= 1'b0;
    end else begin
      read_valid_o <= access_i.read;
      if (access_i.read) begin
        read_data_o <= read_next;
      end
    end
  end

endmodule // test_page_config

`default_nettype wire

// ===== rtl/test_page_pkg.sv
/*
  package for the test-page configuration block: register offsets,
  field positions, reset values and shared types.
  assumes one 100 MHz clock domain and a host register port that
  presents a 6-bit register address with byte-wide read and write data.
*/
// How it works
// - page override supplies address bits five and four
// - override clear: pins when valid, else latch, give whole address
// - page field used only while override set
// - secure clock source chosen by two bits
// - secure clock driven onto D1 if enabled, serial host only
// - three-bit field picks test bit for output
// - five-bit field picks observed test bus
// - reorder bit maps test bus onto port; here it reorders only reads of unmapped offsets, never the pins
// - prbs9 enable, sending waits for command
// - prbs15 enable, sending waits for command
// - uart aux lines off when bit clear
// - pin enable bits drive Dn, serial only
// - spi or uart-aux: only D0 to D4
// - gpio mode: enables direct, values drive pins
// - D1 never gpio while secure clock routed
// - value read shows pins in gpio mode
package test_page_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] page_select_offset = 6'h30;
  localparam logic [5:0] signal_select_one_offset = 6'h31;
  localparam logic [5:0] signal_select_two_offset = 6'h32;
  localparam logic [5:0] pin_output_enable_offset = 6'h33;
  localparam logic [5:0] pin_value_offset = 6'h34;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] page_select_reset = 8'h00;
  localparam logic [7:0] signal_select_one_reset = 8'h00;
  localparam logic [7:0] signal_select_two_reset = 8'h00;
  localparam logic [7:0] pin_output_enable_reset = 8'h80;
  localparam logic [7:0] pin_value_reset = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int page_override_bit = 7;
  localparam int page_field_lsb = 0;
  localparam int secure_clock_lsb = 4;
  localparam int secure_clock_d1_bit = 3;
  localparam int observe_bit_lsb = 0;
  localparam int reorder_bit = 7;
  localparam int prbs9_bit = 6;
  localparam int prbs15_bit = 5;
  localparam int observe_bus_lsb = 0;
  localparam int uart_aux_bit = 7;
  localparam int gpio_mode_bit = 7;
  localparam int secure_clock_pin = 1;
  // pins usable when spi or uart aux lines are active
  localparam logic [6:0] narrow_pin_mask = 7'h1f;
  localparam logic [6:0] pin_mask_reserved = 7'h7f;
  localparam logic [7:0] page_writable_mask = 8'h83;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    clock_off,
    clock_oscillator,
    clock_uart,
    clock_rf_field
  } secure_clock_source_type;

  typedef enum logic [1:0] {
    host_parallel,
    host_spi,
    host_uart,
    host_i2c
  } host_interface_type;

  typedef struct packed {
    logic write;
    logic read;
    logic [5:0] address;
    logic [7:0] write_data;
  } register_access_type;

  typedef struct packed {
    logic prbs9_enable;
    logic prbs15_enable;
    logic [4:0] observe_bus_select;
    logic [2:0] observe_bit_select;
    secure_clock_source_type secure_clock_source;
  } test_control_type;

endpackage : test_page_pkg

// ===== sim/pin_side_model.sv
/*
  far side of the 7-bit data port: whatever is wired to D6..D0.
  assumes the far side drives every pin the device leaves released.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_side_model (
  input wire logic [6:0] drive_i,
  input wire logic [6:0] enable_i,
  input wire logic [6:0] far_i,
  output logic [6:0] level_o
);
  // device wins where it drives; released pins read the far side
  always_comb begin
    for (int n = 0; n < 7; n++) begin
      level_o[n] = enable_i[n] ? drive_i[n] : far_i[n];
    end
  end
endmodule // pin_side_model

`default_nettype wire

// ===== sim/test_page_config_chk.sv
/*
  port-level checker for the test-page register bank.
  assumes one clock domain, asynchronous active-low reset, and that it
  is bound onto test_page_config by the statement at the foot.
*/
`timescale 1ns/1ps
`default_nettype none

module test_page_config_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire test_page_pkg::register_access_type access_i,
  input wire logic [5:0] pin_address_i,
  input wire logic pin_address_valid_i,
  input wire test_page_pkg::host_interface_type host_interface_i,
  input wire logic transmit_command_i,
  input wire logic [6:0] data_pin_oe_o,
  input wire logic [5:0] register_address_o,
  input wire logic [7:0] read_data_o,
  input wire logic read_valid_o,
  input wire logic uart_aux_line_one_oe_o,
  input wire logic uart_aux_line_two_oe_o,
  input wire logic prbs9_send_o,
  input wire logic prbs15_send_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // ----------------------------------------------------------
  // register port
  // ----------------------------------------------------------
  a_read_valid_pulse: assert property (access_i.read |=> read_valid_o)
    else $error("read not answered");
  a_valid_has_cause: assert property
    (read_valid_o |-> $past(access_i.read))
    else $error("read valid without read");
  a_read_data_hold: assert property
    (!read_valid_o |-> $stable(read_data_o))
    else $error("read data moved without read");

  // ----------------------------------------------------------
  // address resolution, pins and lines
  // ----------------------------------------------------------
  // guard on past reset: the first edge after release sees reset values
  a_addr_from_pins: assert property ($past(nrst_i) &&
    $past(pin_address_valid_i) |->
    register_address_o[3:0] == $past(pin_address_i[3:0]))
    else $error("low address bits wrong");
  a_addr_from_latch: assert property ($past(nrst_i) &&
    !$past(pin_address_valid_i) |->
    register_address_o[3:0] == $past(access_i.address[3:0]))
    else $error("latched low address bits wrong");
  a_aux_needs_uart: assert property (uart_aux_line_one_oe_o |->
    $past(host_interface_i) == test_page_pkg::host_uart)
    else $error("aux line on without uart host");
  a_aux_lines_pair: assert property
    (uart_aux_line_one_oe_o == uart_aux_line_two_oe_o)
    else $error("aux lines disagree");
  a_oe_needs_serial: assert property (data_pin_oe_o != 7'h00 |->
    $past(host_interface_i) != test_page_pkg::host_parallel)
    else $error("pin driven under parallel host");
  a_spi_narrow_pins: assert property ($past(nrst_i) &&
    $past(host_interface_i) == test_page_pkg::host_spi |->
    data_pin_oe_o[6:5] == 2'b00) else $error("spi drove D5 or D6");
  a_prbs9_on_cmd: assert property ($rose(prbs9_send_o) |->
    $past(transmit_command_i)) else $error("prbs9 sent unasked");
  a_prbs15_on_cmd: assert property ($rose(prbs15_send_o) |->
    $past(transmit_command_i)) else $error("prbs15 sent unasked");

  c_read_gpio: cover property (access_i.read && access_i.address == 6'h34);
  c_prbs9_sent: cover property ($rose(prbs9_send_o));
  c_aux_on: cover property (uart_aux_line_one_oe_o);
  c_pins_driven: cover property (data_pin_oe_o != 7'h00);
endmodule // test_page_config_chk

bind test_page_config test_page_config_chk chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .access_i(access_i),
  .pin_address_i(pin_address_i),
  .pin_address_valid_i(pin_address_valid_i),
  .host_interface_i(host_interface_i),
  .transmit_command_i(transmit_command_i),
  .data_pin_oe_o(data_pin_oe_o), .register_address_o(register_address_o),
  .read_data_o(read_data_o), .read_valid_o(read_valid_o),
  .uart_aux_line_one_oe_o(uart_aux_line_one_oe_o),
  .uart_aux_line_two_oe_o(uart_aux_line_two_oe_o),
  .prbs9_send_o(prbs9_send_o), .prbs15_send_o(prbs15_send_o));

`default_nettype wire

// ===== sim/testbench.sv
/*
  self-checking bench for the test-page register bank.
  assumes pin_side_model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk_i, nrst_i, pin_address_valid_i, transmit_command_i;
  logic clock_oscillator_i, clock_uart_i, clock_rf_field_i;
  logic read_valid_o, signal_output_pin_o, aux_one, aux_two;
  logic prbs9_send_o, prbs15_send_o, uart_on;
  test_page_pkg::register_access_type access_i;
  test_page_pkg::host_interface_type host_interface_i;
  test_page_pkg::test_control_type test_control_o;
  logic [5:0] pin_address_i, register_address_o, addr;
  logic [7:0] test_bus_i, read_data_o, rd_val;
  logic [6:0] data_pin_i, data_pin_o, data_pin_oe_o, far_level, oe_e, out_e;
  logic [7:0] regs [5]; // model of offsets 0x30..0x34
  int fails, n_checks, seed, i;

  test_page_config dut (.clk_i(clk_i), .nrst_i(nrst_i), .access_i(access_i),
    .pin_address_i(pin_address_i), .pin_address_valid_i(pin_address_valid_i),
    .host_interface_i(host_interface_i), .test_bus_i(test_bus_i),
    .transmit_command_i(transmit_command_i),
    .clock_oscillator_i(clock_oscillator_i), .clock_uart_i(clock_uart_i),
    .clock_rf_field_i(clock_rf_field_i), .data_pin_i(data_pin_i),
    .data_pin_o(data_pin_o), .data_pin_oe_o(data_pin_oe_o),
    .register_address_o(register_address_o), .read_data_o(read_data_o),
    .read_valid_o(read_valid_o), .signal_output_pin_o(signal_output_pin_o),
    .uart_aux_line_one_oe_o(aux_one), .uart_aux_line_two_oe_o(aux_two),
    .prbs9_send_o(prbs9_send_o), .prbs15_send_o(prbs15_send_o),
    .test_control_o(test_control_o));

  pin_side_model pins (.drive_i(data_pin_o), .enable_i(data_pin_oe_o),
    .far_i(far_level), .level_o(data_pin_i));

  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one write, then the model follows; stray offsets are ignored
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_i);
    access_i = '{write: 1'b1, read: 1'b0, address: a, write_data: d};
    @(negedge clk_i);
    access_i.write = 1'b0;
    if (a >= 6'h30 && a <= 6'h34)
      regs[a - 6'h30] = (a == 6'h30) ? (d & 8'h83) : d;
  endtask

  task automatic rd(input logic [5:0] a);
    @(negedge clk_i);
    access_i.read = 1'b1;
    access_i.address = a;
    @(negedge clk_i);
    access_i.read = 1'b0;
    check(read_valid_o, 1'b1);
    rd_val = read_data_o;
  endtask

  task automatic addr_case(input logic valid, input logic [5:0] exp);
    @(negedge clk_i);
    pin_address_valid_i = valid;
    access_i.address = 6'h05;
    repeat (2) @(negedge clk_i);
    check(register_address_o, exp);
  endtask

  // expected pin drive from the register model and the host kind
  task automatic expect_pins;
    logic serial, narrow;
    logic [1:0] src;
    serial = host_interface_i != test_page_pkg::host_parallel;
    uart_on = host_interface_i == test_page_pkg::host_uart && regs[3][7];
    narrow = host_interface_i == test_page_pkg::host_spi || uart_on;
    oe_e = (serial && regs[4][7]) ?
      regs[3][6:0] & (narrow ? 7'h1f : 7'h7f) : 7'h00;
    out_e = regs[4][6:0];
    src = regs[1][5:4];
    // secure clock takes D1 away from gpio
    if (serial && regs[1][3]) begin
      oe_e[1] = 1'b1;
      out_e[1] = src == 2'd0 ? 1'b0 : src == 2'd1 ? clock_oscillator_i :
        src == 2'd2 ? clock_uart_i : clock_rf_field_i;
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // watchdog: the sequence needs well under 5000 cycles
  initial begin
    #200000;
    fails++;
    give_verdict();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    seed = 69;
    nrst_i = 1'b0;
    access_i = '0;
    pin_address_i = 6'h1a;
    pin_address_valid_i = 1'b0;
    host_interface_i = test_page_pkg::host_spi;
    test_bus_i = 8'h00;
    transmit_command_i = 1'b0;
    clock_oscillator_i = 1'b0;
    clock_uart_i = 1'b0;
    clock_rf_field_i = 1'b0;
    far_level = 7'h00;
    regs = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
    repeat (6) @(negedge clk_i);
    nrst_i = 1'b1;
    for (i = 0; i < 5; i++) begin
      rd(6'h30 + 6'(i));
      check(rd_val, regs[i]);
    end
    // reserved page bits read as zero; override on, then off
    wr(6'h30, 8'hff);
    rd(6'h30);
    check(rd_val, 8'h83);
    addr_case(1'b0, 6'h35);
    addr_case(1'b1, 6'h3a);
    wr(6'h30, 8'h01);
    addr_case(1'b0, 6'h05);
    addr_case(1'b1, 6'h1a);
    pin_address_valid_i = 1'b0;
    // random configs, host kinds and pin levels; 0x35 must be ignored
    for (i = 0; i < 80; i++) begin
      @(negedge clk_i);
      host_interface_i =
        test_page_pkg::host_interface_type'(2'($random(seed)));
      {clock_oscillator_i, clock_uart_i, clock_rf_field_i} = 3'($random(seed));
      test_bus_i = 8'($random(seed));
      far_level = 7'($random(seed));
      addr = 6'h31 + 6'($unsigned($random(seed)) % 5);
      wr(addr, 8'($random(seed)));
      repeat (2) @(negedge clk_i);
      expect_pins();
      check(data_pin_oe_o, oe_e);
      check(data_pin_o & oe_e, out_e & oe_e);
      check({aux_one, aux_two}, {uart_on, uart_on});
      check(test_control_o,
        {regs[2][6:0], regs[1][2:0], regs[1][5:4]});
      if (!regs[2][7])
        check(signal_output_pin_o, test_bus_i[regs[1][2:0]]);
      check({prbs9_send_o, prbs15_send_o}, 2'b00);
      rd(6'h34);
      check(rd_val, regs[4][7] ?
        {1'b1, (oe_e & out_e) | (~oe_e & far_level)} : regs[4]);
      if (addr < 6'h34) begin
        rd(addr);
        check(rd_val, regs[addr - 6'h30]);
      end
      rd(6'h35);
      check(rd_val, {1'b0, regs[2][7] ? {test_bus_i[3:2],
        test_bus_i[6:4], test_bus_i[0], test_bus_i[1]} : test_bus_i[6:0]});
    end
    // signal select one cleared first, then each sequence enable and the command
    wr(6'h31, 8'h00);
    for (i = 5; i < 7; i++) begin
      wr(6'h32, 8'h01 << i);
      transmit_command_i = 1'b1;
      @(negedge clk_i);
      transmit_command_i = 1'b0;
      repeat (2) @(negedge clk_i);
      check({prbs9_send_o, prbs15_send_o}, i == 6 ? 2'b10 : 2'b01);
      wr(6'h32, 8'h00);
      repeat (2) @(negedge clk_i);
      check({prbs9_send_o, prbs15_send_o}, 2'b00);
    end
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
